// ===== ppp_pkg.sv
/*
  Constants, timing figures and the acknowledge state type for the parallel
  character port. Assumes a single 25 MHz printer logic clock.
*/
package ppp_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_NS = 40;
  localparam int STB_MIN_NS = 500;
  localparam int STB_GAP_NS = 10500;
  localparam int STB_GAP_CYC = (STB_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACK_DLY_NS = 1000;
  localparam int ACK_W_NS = 2000;
  localparam int ACK_DLY_CYC = (ACK_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACK_W_CYC = (ACK_W_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 16;
  localparam int GAP_W = 9;

  // ==========================================================================
  // Character and FIFO layout
  localparam int DATA_W = 8;
  localparam int BIT_CLS_LO = 6;
  localparam int BIT_CLS_HI = 7;
  localparam int FIFO_DEPTH = 256;
  localparam int PTR_W = 8;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_FULL = 9'h100;
  localparam logic [CNT_W-1:0] CNT_LOW_MARK = 9'h079;

  // ==========================================================================
  // Acknowledge sequencer
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_WAIT = 2'b01,
    ACK_LOW  = 2'b10
  } ppp_ack_t;
endpackage

// ===== ppp_sync.sv
/*
  Two-flop synchroniser for a bus of asynchronous pin levels.
  Assumes the bits are quasi-static or sampled as a group by a qualifying strobe.
*/
`timescale 1ns/1ps
module ppp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // ==========================================================================
  // Stages
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= RST;
      q_ff <= RST;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// ===== ppp_port.sv
/*
  Strobed 8-bit parallel character input port with busy, acknowledge and
  status outputs, a 256-character FIFO and printable/control classing.
  Assumes the printer mechanism drains the FIFO on the read side and reports
  paper, online, fault, encoder and reset-button levels on the printer clock.
*/
`timescale 1ns/1ps
module ppp_port #(
  parameter int ACK_DLY = ppp_pkg::ACK_DLY_CYC,
  parameter int ACK_W = ppp_pkg::ACK_W_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host pins
  input wire logic strobe_n,
  input wire logic [ppp_pkg::DATA_W-1:0] data_in,
  input wire logic remote_motion_stop_n,
  output logic ack_n,
  output logic busy,
  output logic paper_out_flag,
  output logic online_select,
  output logic fault_n,
  // Printer status inputs
  input wire logic paper_out,
  input wire logic online,
  input wire logic fault,
  input wire logic encoder_error,
  input wire logic reset_button,
  input wire logic feed_active,
  // Motion control
  output logic motion_abort,
  // FIFO read side
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [ppp_pkg::DATA_W-1:0] rd_data,
  output logic rd_printable,
  output logic rd_control,
  output logic [ppp_pkg::CNT_W-1:0] fill_count
);
  import ppp_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  logic stb_s;
  logic rms_s;
  logic [DATA_W-1:0] dat_s;

  ppp_sync #(.W(2), .RST(2'h3)) u_sync_ctl (
    .clk(clk),
    .arst_n(arst_n),
    .d({strobe_n, remote_motion_stop_n}),
    .q({stb_s, rms_s})
  );

  // Data passes the same two stages as the strobe so it stays aligned to it.
  ppp_sync #(.W(DATA_W), .RST(8'h00)) u_sync_dat (
    .clk(clk),
    .arst_n(arst_n),
    .d(data_in),
    .q(dat_s)
  );

  // ==========================================================================
  // Strobe edge and spacing
  logic stb_prev_ff;
  logic nxt_stb_prev;
  logic [GAP_W-1:0] gap_ff;
  logic [GAP_W-1:0] nxt_gap;
  logic stb_trail;
  logic gap_ok;
  logic accept;

  localparam logic [GAP_W-1:0] GAP_SAT = GAP_W'(STB_GAP_CYC);

  assign stb_trail = stb_s & ~stb_prev_ff;
  assign gap_ok = (gap_ff >= GAP_SAT);

  // ==========================================================================
  // Acknowledge sequencer and busy causes
  ppp_ack_t ack_st_ff;
  ppp_ack_t nxt_ack_st;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] nxt_tmr;
  logic ack_n_ff;
  logic nxt_ack_n;
  logic full_busy_ff;
  logic nxt_full_busy;
  logic err_busy_ff;
  logic nxt_err_busy;
  logic off_busy_ff;
  logic nxt_off_busy;
  logic busy_ff;
  logic nxt_busy;

  // ==========================================================================
  // FIFO state
  logic [DATA_W-1:0] mem_ff [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] nxt_wr_ptr;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W-1:0] nxt_rd_ptr;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic do_rd;

  // An offline or error busy strobe is only taken when far enough from the last one;
  // a full FIFO, or full-busy held down to the low mark, refuses outright.
  assign accept = stb_trail && (ack_st_ff == ACK_IDLE) && (cnt_ff != CNT_FULL)
                  && !full_busy_ff && (!busy_ff || gap_ok);
  assign do_rd = rd_valid && rd_ready;

  always_comb begin
    nxt_stb_prev = stb_s;
    nxt_gap = gap_ff;
    if (accept) begin
      nxt_gap = '0;
    end else if (!gap_ok) begin
      nxt_gap = gap_ff + GAP_W'(1);
    end
  end

  always_comb begin
    nxt_ack_st = ack_st_ff;
    nxt_tmr = tmr_ff;
    nxt_ack_n = 1'b1;
    unique case (ack_st_ff)
      ACK_IDLE: begin
        if (accept) begin
          nxt_ack_st = ACK_WAIT;
          nxt_tmr = TMR_W'(ACK_DLY);
        end
      end
      ACK_WAIT: begin
        if (tmr_ff <= TMR_W'(1)) begin
          nxt_ack_st = ACK_LOW;
          nxt_tmr = TMR_W'(ACK_W);
          nxt_ack_n = 1'b0;
        end else begin
          nxt_tmr = tmr_ff - TMR_W'(1);
        end
      end
      ACK_LOW: begin
        if (tmr_ff <= TMR_W'(1)) begin
          nxt_ack_st = ACK_IDLE;
        end else begin
          nxt_tmr = tmr_ff - TMR_W'(1);
          nxt_ack_n = 1'b0;
        end
      end
      default: begin
        nxt_ack_st = ACK_IDLE;
      end
    endcase
  end

  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_cnt = cnt_ff;
    if (accept) begin
      nxt_wr_ptr = wr_ptr_ff + PTR_W'(1);
    end
    if (do_rd) begin
      nxt_rd_ptr = rd_ptr_ff + PTR_W'(1);
    end
    if (accept && !do_rd) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end else if (!accept && do_rd) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
    end
  end

  always_comb begin
    if (full_busy_ff) begin
      nxt_full_busy = (nxt_cnt > CNT_LOW_MARK);
    end else begin
      nxt_full_busy = (nxt_cnt == CNT_FULL);
    end
    // A new error in the same cycle as the button press keeps busy set.
    if (encoder_error || paper_out) begin
      nxt_err_busy = 1'b1;
    end else if (reset_button) begin
      nxt_err_busy = 1'b0;
    end else begin
      nxt_err_busy = err_busy_ff;
    end
    nxt_off_busy = !online;
    nxt_busy = nxt_full_busy || nxt_err_busy || nxt_off_busy;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stb_prev_ff <= 1'b1;
      gap_ff <= GAP_SAT;
      ack_st_ff <= ACK_IDLE;
      tmr_ff <= '0;
      ack_n_ff <= 1'b1;
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      full_busy_ff <= 1'b0;
      err_busy_ff <= 1'b0;
      off_busy_ff <= 1'b1;
      busy_ff <= 1'b1;
    end else begin
      stb_prev_ff <= nxt_stb_prev;
      gap_ff <= nxt_gap;
      ack_st_ff <= nxt_ack_st;
      tmr_ff <= nxt_tmr;
      ack_n_ff <= nxt_ack_n;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff <= nxt_cnt;
      full_busy_ff <= nxt_full_busy;
      err_busy_ff <= nxt_err_busy;
      off_busy_ff <= nxt_off_busy;
      busy_ff <= nxt_busy;
    end
  end

  // Storage has no reset; reads are gated by the count, so old contents
  // are never presented with rd_valid high.
  always_ff @(posedge clk) begin
    if (accept) begin
      mem_ff[wr_ptr_ff] <= dat_s;
    end
  end

  // ==========================================================================
  // Status pins
  logic po_ff;
  logic nxt_po;
  logic sel_ff;
  logic nxt_sel;
  logic flt_n_ff;
  logic nxt_flt_n;
  logic abort_ff;
  logic nxt_abort;

  always_comb begin
    nxt_po = paper_out;
    nxt_sel = online;
    nxt_flt_n = !fault;
    nxt_abort = feed_active && !rms_s;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      po_ff <= 1'b0;
      sel_ff <= 1'b0;
      flt_n_ff <= 1'b1;
      abort_ff <= 1'b0;
    end else begin
      po_ff <= nxt_po;
      sel_ff <= nxt_sel;
      flt_n_ff <= nxt_flt_n;
      abort_ff <= nxt_abort;
    end
  end

  // ==========================================================================
  // Outputs
  assign ack_n = ack_n_ff;
  assign busy = busy_ff;
  assign paper_out_flag = po_ff;
  assign online_select = sel_ff;
  assign fault_n = flt_n_ff;
  assign motion_abort = abort_ff;
  assign rd_valid = (cnt_ff != '0);
  assign rd_data = mem_ff[rd_ptr_ff];
  assign rd_printable = rd_data[BIT_CLS_LO] || rd_data[BIT_CLS_HI];
  assign rd_control = !rd_printable;
  assign fill_count = cnt_ff;
endmodule

// ===== ppp_port_chk.sv
/*
  Assertion checker for the parallel character port, bound to ppp_port.
  Assumes it sees only the port's pins on the port's clock and reset.
*/
`timescale 1ns/1ps
module ppp_port_chk #(
  parameter int ACK_W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host pins
  input wire logic remote_motion_stop_n,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic paper_out_flag,
  input wire logic fault_n,
  // Printer status and motion
  input wire logic paper_out,
  input wire logic online,
  input wire logic fault,
  input wire logic encoder_error,
  input wire logic reset_button,
  input wire logic feed_active,
  input wire logic motion_abort,
  // FIFO read side
  input wire logic rd_ready,
  input wire logic [ppp_pkg::CNT_W-1:0] fill_count
);
  import ppp_pkg::*;
  // Length of the current acknowledge pulse, so its width can be checked exactly.
  logic [7:0] low_ff;
  logic [7:0] nxt_low;
  always_comb begin
    nxt_low = ack_n ? 8'h00 : low_ff + 8'h01;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) low_ff <= 8'h00;
    else low_ff <= nxt_low;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_ack_w; $rose(ack_n) |-> low_ff == ACK_W; endproperty
  a_ack_w: assert property (p_ack_w) else $error("ack pulse width wrong");
  property p_ack_after; fill_count > $past(fill_count) |-> ##[0:40] !ack_n; endproperty
  a_ack_after: assert property (p_ack_after) else $error("no ack after write");
  property p_full; fill_count == CNT_FULL |-> busy; endproperty
  a_full: assert property (p_full) else $error("full without busy");
  property p_hold_full; fill_count == CNT_FULL && !rd_ready |=> fill_count == CNT_FULL;
  endproperty
  a_hold_full: assert property (p_hold_full) else $error("write while full");
  property p_paper; paper_out |=> paper_out_flag && busy; endproperty
  a_paper: assert property (p_paper) else $error("paper out not shown");
  property p_offline; !online |=> busy; endproperty
  a_offline: assert property (p_offline) else $error("offline not busy");
  property p_enc; encoder_error |=> busy; endproperty
  a_enc: assert property (p_enc) else $error("encoder error not busy");
  property p_clear;
    reset_button && online && !paper_out && !encoder_error && fill_count <= CNT_LOW_MARK
      |=> !busy;
  endproperty
  a_clear: assert property (p_clear) else $error("busy not cleared");
  property p_fault; 1'b1 |=> fault_n == !$past(fault); endproperty
  a_fault: assert property (p_fault) else $error("fault output wrong");
  property p_stop; (!remote_motion_stop_n && feed_active) [*4] |-> motion_abort; endproperty
  a_stop: assert property (p_stop) else $error("motion not stopped");
endmodule

// ===== ppp_host.sv
/*
  Host model that strobes characters into the port one at a time.
  Assumes the bench calls send from its main process.
*/
`timescale 1ns/1ps
module ppp_host (
  // Clock and pins
  input wire logic clk,
  input wire logic ack_n,
  output logic strobe_n,
  output logic [ppp_pkg::DATA_W-1:0] data_in
);
  import ppp_pkg::*;
  initial begin
    strobe_n = 1'b1;
    data_in = 8'h00;
  end
  // Data is held until acknowledge ends, then inverted so stale bits never pass.
  task automatic send(input logic [DATA_W-1:0] b, output bit acked);
    int n;
    @(posedge clk);
    data_in <= b;
    strobe_n <= 1'b0;
    repeat (STB_MIN_NS / CLK_NS + 1) @(posedge clk);
    strobe_n <= 1'b1;
    for (n = 0; n < 60 && ack_n !== 1'b0; n++) @(negedge clk);
    acked = ack_n === 1'b0;
    for (n = 0; n < 60 && ack_n !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    data_in <= ~b;
  endtask
endmodule

// ===== test_ppp_port.sv
/*
  Self-checking bench for the parallel character port.
  Assumes ppp_pkg, ppp_host and ppp_port_chk are compiled first.
*/
`timescale 1ns/1ps
module test_ppp_port;
  import ppp_pkg::*;
  localparam int ACK_DLY = 1;
  localparam int ACK_W = 2;
  logic clk = 1'b0, arst_n = 1'b0, remote_motion_stop_n = 1'b1, rd_ready = 1'b0;
  logic paper_out = 1'b0, online = 1'b1, fault = 1'b0, encoder_error = 1'b0;
  logic reset_button = 1'b0, feed_active = 1'b0, full_b = 1'b0;
  logic strobe_n, ack_n, busy, paper_out_flag, online_select, fault_n, motion_abort;
  logic rd_valid, rd_printable, rd_control;
  logic [DATA_W-1:0] data_in, rd_data;
  logic [CNT_W-1:0] fill_count;
  int err_total = 0, num_checks = 0, seed = 6398, q[$];
  bit ok;
  always #20 clk = ~clk;
  ppp_host host (.clk(clk), .ack_n(ack_n), .strobe_n(strobe_n), .data_in(data_in));
  ppp_port #(.ACK_DLY(ACK_DLY), .ACK_W(ACK_W)) dut (
    .clk(clk), .arst_n(arst_n), .strobe_n(strobe_n), .data_in(data_in),
    .remote_motion_stop_n(remote_motion_stop_n), .ack_n(ack_n), .busy(busy),
    .paper_out_flag(paper_out_flag), .online_select(online_select), .fault_n(fault_n),
    .paper_out(paper_out), .online(online), .fault(fault), .encoder_error(encoder_error),
    .reset_button(reset_button), .feed_active(feed_active), .motion_abort(motion_abort),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_printable(rd_printable), .rd_control(rd_control), .fill_count(fill_count)
  );
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  task automatic put(input logic [7:0] b);
    host.send(b, ok);
    check("ack", ok, 1'b1);
    if (!ok) end_of_test();
    q.push_back(b);
    @(negedge clk);
    check("fill", fill_count, 16'(q.size()));
  endtask
  // Reads the head at a quiet negedge, then pops it with a one-cycle ready.
  task automatic take;
    int e;
    @(negedge clk);
    e = q[0];
    check("data", {rd_valid, rd_data}, {1'b1, e[7:0]});
    check("class", {rd_printable, rd_control}, {e[7] | e[6], ~(e[7] | e[6])});
    check("busy", busy, full_b);
    @(posedge clk) rd_ready <= 1'b1;
    @(posedge clk) rd_ready <= 1'b0;
    void'(q.pop_front());
    if (q.size() <= 121) full_b = 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    check("idle", {busy, online_select, fault_n}, 3'b011);
    for (int i = 0; i < FIFO_DEPTH; i++) put(8'($random(seed)));
    full_b = 1'b1;
    check("full", busy, 1'b1);
    host.send(8'h41, ok);
    check("refused", {ok, fill_count}, {1'b0, 9'h100});
    while (q.size() > 0) take();
    @(posedge clk) online <= 1'b0;
    settle();
    check("offline", {busy, online_select}, 2'b10);
    put(8'h0d);
    host.send(8'h0a, ok);
    check("close", ok, 1'b0);
    repeat (STB_GAP_CYC) @(posedge clk);
    put(8'h0a);
    @(posedge clk) online <= 1'b1;
    settle();
    check("online", {busy, online_select}, 2'b01);
    take();
    take();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) {encoder_error, paper_out} <= i ? 2'b10 : 2'b01;
      settle();
      check("err", {paper_out_flag, busy}, {i == 0, 1'b1});
      @(posedge clk) {encoder_error, paper_out} <= 2'b00;
      settle();
      check("held", busy, 1'b1);
      @(posedge clk) reset_button <= 1'b1;
      @(posedge clk) reset_button <= 1'b0;
      settle();
      check("clear", {paper_out_flag, busy}, 2'b00);
    end
    @(posedge clk) fault <= 1'b1;
    settle();
    check("fault", fault_n, 1'b0);
    @(posedge clk) begin
      fault <= 1'b0;
      feed_active <= 1'b1;
      remote_motion_stop_n <= 1'b0;
    end
    settle();
    check("stop", {fault_n, motion_abort}, 2'b11);
    @(posedge clk) remote_motion_stop_n <= 1'b1;
    settle();
    check("run", motion_abort, 1'b0);
    end_of_test();
  end
endmodule
bind ppp_port ppp_port_chk #(.ACK_W(ACK_W)) chk (
  .clk(clk), .arst_n(arst_n), .remote_motion_stop_n(remote_motion_stop_n),
  .ack_n(ack_n), .busy(busy), .paper_out_flag(paper_out_flag), .fault_n(fault_n),
  .paper_out(paper_out), .online(online), .fault(fault), .encoder_error(encoder_error),
  .reset_button(reset_button), .feed_active(feed_active), .motion_abort(motion_abort),
  .rd_ready(rd_ready), .fill_count(fill_count)
);
